//--- logic/stp_pkg.sv
// package: constants for the stack top pointer block
package stp_pkg;
	localparam int unsigned STP_PTR_W   = 16;
	localparam int unsigned STP_DATA_W  = 16;
	localparam int unsigned STP_CNT_W   = 2;
	// internal ram window as 16-bit pointer bounds (parameterisable at top)
	localparam logic [15:0] STP_RAM_LO  = 16'he000;
	localparam logic [15:0] STP_RAM_HI  = 16'hfedf;
	localparam logic [15:0] STP_PTR_RST = 16'h0000;
	typedef enum logic [3:0] {
		STP_IDLE  = 4'h1,
		STP_PUSHW = 4'h2,
		STP_POPR  = 4'h4,
		STP_POPI  = 4'h8
	} stp_state_t;
endpackage

//--- logic/stp_stack_pointer.sv
// stack top pointer register with push/pop address sequencing
`timescale 1ns/10ps
`default_nettype none
module stp_stack_pointer #(
	parameter logic [15:0] RAM_LO = stp_pkg::STP_RAM_LO,
	parameter logic [15:0] RAM_HI = stp_pkg::STP_RAM_HI
) (
	// clock and reset
	input  wire logic                          sys_clk,
	input  wire logic                          reset_n,
	// software load of the pointer
	input  wire logic                          load_req,
	input  wire logic [stp_pkg::STP_PTR_W-1:0] load_value,
	// stack operation request
	input  wire logic                          push_req,
	input  wire logic                          pop_req,
	input  wire logic [stp_pkg::STP_CNT_W-1:0] op_bytes,
	input  wire logic [stp_pkg::STP_DATA_W-1:0] push_data,
	output logic                               op_ready,
	output logic                               op_done,
	output logic [stp_pkg::STP_DATA_W-1:0]     pop_data,
	output logic                               range_err,
	// pointer view
	output logic [stp_pkg::STP_PTR_W-1:0]      stack_top_pointer,
	output logic                               ptr_valid,
	// internal ram port
	output logic                               mem_we,
	output logic                               mem_re,
	output logic [stp_pkg::STP_PTR_W-1:0]      mem_addr,
	output logic [stp_pkg::STP_DATA_W-1:0]     mem_wdata,
	output logic [stp_pkg::STP_CNT_W-1:0]      mem_bytes,
	input  wire logic [stp_pkg::STP_DATA_W-1:0] mem_rdata
);
	import stp_pkg::*;

	// one spare bit above the pointer catches pop wrap, and push wrap from pointer 0 only, in range checks
	localparam logic [STP_PTR_W:0] STEP_ONE = {{STP_PTR_W{1'h0}}, 1'h1};
	localparam logic [STP_PTR_W:0] LO_EXT   = {1'h0, RAM_LO};
	localparam logic [STP_PTR_W:0] HI_EXT   = {1'h0, RAM_HI};

	// sequencer state
	stp_state_t            st_r;
	stp_state_t            st_nxt;
	// pointer and its load flag
	logic [STP_PTR_W-1:0]  sp_r;
	logic [STP_PTR_W-1:0]  sp_nxt;
	logic                  val_r;
	logic                  val_nxt;
	// operation latches
	logic [STP_CNT_W-1:0]  cnt_r;
	logic [STP_CNT_W-1:0]  cnt_nxt;
	logic [STP_DATA_W-1:0] wd_r;
	logic [STP_DATA_W-1:0] wd_nxt;
	logic [STP_DATA_W-1:0] rd_r;
	logic [STP_DATA_W-1:0] rd_nxt;
	// status pulses
	logic                  done_r;
	logic                  done_nxt;
	logic                  err_r;
	logic                  err_nxt;
	// request decode
	logic                  idle;
	logic                  take_load;
	logic                  take_op;
	logic                  refuse_undef;
	logic                  refuse_range;
	logic                  accept_push;
	logic                  accept_pop;
	// address arithmetic
	logic [STP_PTR_W:0]    step_ext;
	logic [STP_PTR_W:0]    push_lo;
	logic [STP_PTR_W:0]    push_hi;
	logic [STP_PTR_W:0]    pop_lo;
	logic [STP_PTR_W:0]    pop_hi;
	logic [STP_PTR_W-1:0]  dec_addr;
	logic [STP_PTR_W-1:0]  inc_addr;
	logic                  push_in_ram;
	logic                  pop_in_ram;

	// every byte a pop reads, and every byte a push writes unless it wraps from pointer 1 or 2, must lie in the window
	assign step_ext    = {{(STP_PTR_W + 1 - STP_CNT_W){1'h0}}, op_bytes};
	assign push_lo     = {1'h0, sp_r} - step_ext;
	assign push_hi     = {1'h0, sp_r} - STEP_ONE;
	assign pop_lo      = {1'h0, sp_r};
	assign pop_hi      = {1'h0, sp_r} + step_ext - STEP_ONE;
	assign dec_addr    = push_lo[STP_PTR_W-1:0];
	assign inc_addr    = sp_r + {{(STP_PTR_W - STP_CNT_W){1'h0}}, cnt_r};
	assign push_in_ram = (push_lo >= LO_EXT) && (push_hi <= HI_EXT);
	assign pop_in_ram  = (pop_lo >= LO_EXT) && (pop_hi <= HI_EXT);

	// requests are taken only in idle; load wins over push, push over pop
	assign idle         = (st_r == STP_IDLE);
	assign take_load    = idle && load_req;
	assign take_op      = idle && !load_req && (push_req || pop_req);
	assign refuse_undef = take_op && (!val_r || op_bytes == '0);
	assign refuse_range = take_op && !refuse_undef &&
		(push_req ? !push_in_ram : !pop_in_ram);
	assign accept_push  = take_op && !refuse_undef && !refuse_range && push_req;
	assign accept_pop   = take_op && !refuse_undef && !refuse_range && !push_req;

	// sequencer
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			STP_IDLE: begin
				if (accept_push) begin
					st_nxt = STP_PUSHW;
				end else if (accept_pop) begin
					st_nxt = STP_POPR;
				end
			end
			STP_PUSHW: begin
				st_nxt = STP_IDLE;
			end
			STP_POPR: begin
				st_nxt = STP_POPI;
			end
			STP_POPI: begin
				st_nxt = STP_IDLE;
			end
			default: begin
				st_nxt = STP_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			st_r <= STP_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// pointer: lowered before the write, raised after the read
	always_comb begin
		sp_nxt  = sp_r;
		val_nxt = val_r;
		if (take_load) begin
			sp_nxt  = load_value;
			val_nxt = 1'h1;
		end else if (accept_push) begin
			sp_nxt = dec_addr;
		end else if (st_r == STP_POPI) begin
			sp_nxt = inc_addr;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			sp_r  <= STP_PTR_RST;
			val_r <= 1'h0;
		end else begin
			sp_r  <= sp_nxt;
			val_r <= val_nxt;
		end
	end

	// operation latches
	always_comb begin
		cnt_nxt = cnt_r;
		wd_nxt  = wd_r;
		rd_nxt  = rd_r;
		if (accept_push || accept_pop) begin
			cnt_nxt = op_bytes;
		end
		if (accept_push) begin
			wd_nxt = push_data;
		end
		if (st_r == STP_POPR) begin
			rd_nxt = mem_rdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			cnt_r <= '0;
			wd_r  <= '0;
			rd_r  <= '0;
		end else begin
			cnt_r <= cnt_nxt;
			wd_r  <= wd_nxt;
			rd_r  <= rd_nxt;
		end
	end

	// status pulses
	always_comb begin
		done_nxt = 1'h0;
		err_nxt  = 1'h0;
		if (refuse_undef || refuse_range) begin
			done_nxt = 1'h1;
			err_nxt  = 1'h1;
		end else if (st_r == STP_PUSHW || st_r == STP_POPI) begin
			done_nxt = 1'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			done_r <= 1'h0;
			err_r  <= 1'h0;
		end else begin
			done_r <= done_nxt;
			err_r  <= err_nxt;
		end
	end

	// outputs

	assign op_ready          = (st_r == STP_IDLE);
	assign op_done           = done_r;
	assign range_err         = err_r;
	assign pop_data          = rd_r;
	assign stack_top_pointer = sp_r;
	assign ptr_valid         = val_r;
	assign mem_we            = (st_r == STP_PUSHW);
	assign mem_re            = (st_r == STP_POPR);
	assign mem_addr          = sp_r;
	assign mem_wdata         = wd_r;
	assign mem_bytes         = cnt_r;
endmodule
`default_nettype wire

//--- verif/cpu_stack_pointer_tb.sv
// bench for the stack top pointer
`timescale 1ns/10ps
`default_nettype none
module cpu_stack_pointer_tb;
	logic sys_clk = 0, reset_n = 0, load_req = 0, push_req = 0, pop_req = 0, op_ready, op_done;
	logic range_err, ptr_valid, mem_we, mem_re;
	logic [1:0] op_bytes = 2'h0, mem_bytes;
	logic [15:0] load_value = 16'h0, push_data = 16'h0, pop_data, stack_top_pointer, mem_addr;
	logic [15:0] mem_wdata, mem_rdata;
	int errors = 0, checks_done = 0;
	stp_stack_pointer dut (.sys_clk(sys_clk), .reset_n(reset_n), .load_req(load_req),
		.load_value(load_value), .push_req(push_req), .pop_req(pop_req), .op_bytes(op_bytes),
		.push_data(push_data), .op_ready(op_ready), .op_done(op_done), .pop_data(pop_data),
		.range_err(range_err), .stack_top_pointer(stack_top_pointer), .ptr_valid(ptr_valid),
		.mem_we(mem_we), .mem_re(mem_re), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_bytes(mem_bytes), .mem_rdata(mem_rdata));
	stp_ram_model ram (.sys_clk(sys_clk), .mem_we(mem_we), .mem_re(mem_re),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
	initial forever #2.5 sys_clk = ~sys_clk;
	task stop_test;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// one operation; d is push data, or expected pop data; s is expected pointer
	task op(input logic ps, pp, input logic [1:0] n, input logic [15:0] d, s, input logic e);
		@(negedge sys_clk) {push_req, pop_req, op_bytes, push_data} = {ps, pp, n, d};
		@(negedge sys_clk) {push_req, pop_req} = 2'h0;
		for (int i = 0; i < 4 && op_done !== 1'b1; i++) @(negedge sys_clk);
		checks_done++;
		if (op_done !== 1'b1 || range_err !== e || stack_top_pointer !== s || pp && pop_data !== d) begin
			errors++;
			$display("ERROR %0t mismatch, pointer %h", $time, stack_top_pointer);
		end
	endtask
	// software load of the pointer, checked one cycle later
	task ld(input logic [15:0] v);
		@(negedge sys_clk) {load_req, load_value} = {1'h1, v};
		@(negedge sys_clk) load_req = 1'h0;
		checks_done++;
		if (ptr_valid !== 1'h1 || stack_top_pointer !== v) begin
			errors++;
			$display("ERROR %0t load not taken, pointer %h", $time, stack_top_pointer);
		end
	endtask
	task t_refuse;
		checks_done++;
		if (ptr_valid !== 1'h0 || op_ready !== 1'h1) begin
			errors++;
			$display("ERROR %0t pointer valid or busy after reset", $time);
		end
		op(1'h1, 1'h0, 2'h1, 16'h0, 16'h0, 1'h1);
		op(1'h0, 1'h1, 2'h1, 16'h0, 16'h0, 1'h1);
		ld(16'he001);
		op(1'h1, 1'h0, 2'h0, 16'h0, 16'he001, 1'h1);
		op(1'h1, 1'h0, 2'h1, 16'h0, 16'he000, 1'h0);
		op(1'h1, 1'h0, 2'h1, 16'h0, 16'he000, 1'h1);
		ld(16'hff00);
		op(1'h0, 1'h1, 2'h1, 16'h0, 16'hff00, 1'h1);
		op(1'h1, 1'h0, 2'h1, 16'h0, 16'hff00, 1'h1);
		$display("refusal test done");
	endtask
	task t_lifo;
		ld(16'hf000); // stack kept clear of bank and flash work areas
		op(1'h1, 1'h0, 2'h2, 16'h1234, 16'heffe, 1'h0);
		op(1'h1, 1'h0, 2'h3, 16'habcd, 16'heffb, 1'h0);
		op(1'h0, 1'h1, 2'h3, 16'habcd, 16'heffe, 1'h0);
		op(1'h0, 1'h1, 2'h2, 16'h1234, 16'hf000, 1'h0);
		$display("lifo test done");
	endtask
	initial begin
		repeat (12) @(negedge sys_clk);
		reset_n = 1'h1;
		t_refuse;
		t_lifo;
		stop_test;
	end
	initial #5000 begin
		errors++;
		stop_test;
	end
endmodule
`default_nettype wire

//--- verif/stp_monitor.sv
// checker bound to the stack pointer
`timescale 1ns/10ps
`default_nettype none
module stp_monitor #(parameter logic [15:0] RAM_LO = 16'h0, RAM_HI = 16'h0) (
	input wire logic sys_clk, reset_n, load_req, op_ready, push_req, ptr_valid, op_done,
	input wire logic range_err, mem_we, mem_re, input wire logic [1:0] mem_bytes,
	input wire logic [15:0] load_value, stack_top_pointer, mem_addr);
	wire logic [15:0] sp = stack_top_pointer;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	AST_LD: assert property (load_req && op_ready |=> sp == $past(load_value)) else $error("ld");
	AST_RAM: assert property (mem_we || mem_re |->
		mem_addr >= RAM_LO && {1'h0, mem_addr} + mem_bytes - 17'h1 <= {1'h0, RAM_HI})
		else $error("ram");
	AST_PUSH: assert property (mem_we |-> mem_addr == sp ##1 op_done) else $error("push");
	AST_POP: assert property (mem_re |-> mem_addr == sp ##1 $stable(sp)) else $error("pop");
	AST_UNDEF: assert property (op_ready && push_req && !load_req && !ptr_valid |=>
		op_done && range_err) else $error("undef");
	AST_STEP: assert property (mem_we |-> sp == $past(sp) - mem_bytes) else $error("step");
	cover property (mem_we);
	cover property (mem_re);
	cover property (range_err);
endmodule
bind stp_stack_pointer stp_monitor #(.RAM_LO(RAM_LO), .RAM_HI(RAM_HI)) mon (.sys_clk(sys_clk),
	.reset_n(reset_n), .load_req(load_req), .op_ready(op_ready), .push_req(push_req),
	.ptr_valid(ptr_valid), .op_done(op_done), .range_err(range_err), .mem_we(mem_we),
	.mem_re(mem_re), .mem_bytes(mem_bytes), .load_value(load_value),
	.stack_top_pointer(stack_top_pointer), .mem_addr(mem_addr));
`default_nettype wire

//--- verif/stp_ram_model.sv
// partner: internal ram holding the stack area
`timescale 1ns/10ps
`default_nettype none
module stp_ram_model (input wire logic sys_clk, mem_we, mem_re, input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata, output logic [15:0] mem_rdata);
	logic [15:0] mem [0:65535];
	always_ff @(posedge sys_clk) if (mem_we) mem[mem_addr] <= mem_wdata;
	// read data only in the read cycle, a toggling pattern otherwise
	assign mem_rdata = mem_re ? mem[mem_addr] : {8{sys_clk, ~sys_clk}};
endmodule
`default_nettype wire
